// ---- common/efb_consts.svh ----
// Offsets, reset values and field positions for the fail-safe config bank.
// Assumes inclusion by name from the design and bench files.
`ifndef EFB_CONSTS_SVH
`define EFB_CONSTS_SVH
`define EFB_OFF_DUTY7     8'hA7
`define EFB_OFF_DUTY8     8'hA8
`define EFB_OFF_DUTY9     8'hA9
`define EFB_OFF_DUTY10    8'hAA
`define EFB_OFF_DUTY11    8'hAB
`define EFB_OFF_FS0_LO    8'hC0
`define EFB_OFF_FS0_HI    8'hC1
`define EFB_OFF_FS1_LO    8'hC2
`define EFB_OFF_FS1_HI    8'hC3
`define EFB_OFF_STATUS    8'hCF
`define EFB_RST_DUTY      8'hFF
`define EFB_RST_FS0_LO    8'h00
`define EFB_RST_FS0_HI    4'h0
`define EFB_RST_FS1_LO    8'hFF
`define EFB_RST_FS1_HI    4'hF
`define EFB_DUTY_FIRST    3'h0
`define EFB_DUTY_LAST     3'h4
`define EFB_HI_PAD        4'h0
`define EFB_ZERO8         8'h00
`define EFB_CHAN_OFF      12'h000
`endif

// ---- common/efb_pkg.sv ----
// Types for the fail-safe config bank.
// Assumes efb_consts.svh on the include path.
package efb_pkg;
  // Active fail-safe selection
  typedef enum logic [1:0] {
    EFB_FS_NONE,
    EFB_FS_ZERO,
    EFB_FS_ONE
  } efb_fs_t;
  typedef logic [7:0]  efb_byte_t;
  typedef logic [11:0] efb_mask_t;
endpackage

// ---- rtl/efb_duty_mem.sv ----
// Five-entry store of duty defaults, channels 7 to 11.
// Assumes index 0 is channel 7; read data registered.
`timescale 1ns/10ps
`default_nettype none
`include "efb_consts.svh"
module efb_duty_mem
  import efb_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Write port
  input  wire logic       we,
  input  wire logic [2:0] waddr,
  input  wire efb_byte_t  wdata,
  // Read port
  input  wire logic [2:0] raddr,
  output efb_byte_t       rdata,
  // All entries for the channel logic
  output logic [39:0]     all_flat
);
  efb_byte_t mem_q [0:4];   // Duty entries

  // Storage, all ones after reset
  always_ff @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (rst) begin
        mem_q[i] <= `EFB_RST_DUTY;
      end else if (we && waddr == 3'(i)) begin
        mem_q[i] <= wdata;
      end
    end
  end

  // Registered read; out of range reads as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `EFB_ZERO8;
    end else if (raddr <= `EFB_DUTY_LAST) begin
      rdata <= mem_q[raddr];
    end else begin
      rdata <= `EFB_ZERO8;
    end
  end

  // Flattened view
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      all_flat[i*8 +: 8] = mem_q[i];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/efb_bank.sv ----
// Stored duty defaults ch7..11 and fail-safe enable masks, with outputs.
// Assumes a simple strobe register port and external fail-safe requests.
`timescale 1ns/10ps
`default_nettype none
`include "efb_consts.svh"
module efb_bank
  import efb_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire efb_byte_t  reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output efb_byte_t       reg_rdata,
  // Fail-safe requests; state 1 wins if both
  input  wire logic       failsafe_zero_req,
  input  wire logic       failsafe_one_req,
  // Channel outputs
  output efb_mask_t       chan_on,
  output logic            failsafe_active,
  output efb_byte_t       stored_duty_value_ch7,
  output efb_byte_t       stored_duty_value_ch8,
  output efb_byte_t       stored_duty_value_ch9,
  output efb_byte_t       stored_duty_value_ch10,
  output efb_byte_t       stored_duty_value_ch11
);
  // Map an address to a duty entry index, or none
  function automatic logic duty_hit(input logic [7:0] a);
    return a >= `EFB_OFF_DUTY7 && a <= `EFB_OFF_DUTY11;
  endfunction
  function automatic logic [2:0] duty_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `EFB_OFF_DUTY7;
    return d[2:0];
  endfunction

  efb_byte_t  fs0_lo_q;   // State 0, ch0..7
  logic [3:0] fs0_hi_q;   // State 0, ch8..11
  efb_byte_t  fs1_lo_q;   // State 1, ch0..7
  logic [3:0] fs1_hi_q;   // State 1, ch8..11
  efb_fs_t    mode_q;     // Active fail-safe
  efb_mask_t  chan_q;     // Registered channel drive
  efb_byte_t  mask_rd_q;  // Read data from mask registers
  logic       sel_mem_q;  // Read came from duty store
  logic [39:0] duty_flat; // All duty entries
  efb_byte_t  mem_rdata;  // Duty store read data

  // Duty defaults live in a small memory of their own
  efb_duty_mem u_mem (
    .clk      (clk),
    .rst      (rst),
    .we       (reg_wr && duty_hit(reg_addr)),
    .waddr    (duty_idx(reg_addr)),
    .wdata    (reg_wdata),
    .raddr    (duty_idx(reg_addr)),
    .rdata    (mem_rdata),
    .all_flat (duty_flat)
  );

  // Mask registers; upper nibbles are not stored so read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      fs0_lo_q <= `EFB_RST_FS0_LO;
      fs0_hi_q <= `EFB_RST_FS0_HI;
      fs1_lo_q <= `EFB_RST_FS1_LO;
      fs1_hi_q <= `EFB_RST_FS1_HI;
    end else if (reg_wr) begin
      case (reg_addr)
        `EFB_OFF_FS0_LO: fs0_lo_q <= reg_wdata;
        `EFB_OFF_FS0_HI: fs0_hi_q <= reg_wdata[3:0];
        `EFB_OFF_FS1_LO: fs1_lo_q <= reg_wdata;
        `EFB_OFF_FS1_HI: fs1_hi_q <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Read mux for masks and status; unmapped reads as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_rd_q <= `EFB_ZERO8;
      sel_mem_q <= 1'b0;
    end else begin
      sel_mem_q <= reg_rd && duty_hit(reg_addr);
      mask_rd_q <= `EFB_ZERO8;
      if (reg_rd) begin
        case (reg_addr)
          `EFB_OFF_FS0_LO: mask_rd_q <= fs0_lo_q;
          `EFB_OFF_FS0_HI: mask_rd_q <= {`EFB_HI_PAD, fs0_hi_q};
          `EFB_OFF_FS1_LO: mask_rd_q <= fs1_lo_q;
          `EFB_OFF_FS1_HI: mask_rd_q <= {`EFB_HI_PAD, fs1_hi_q};
          `EFB_OFF_STATUS: mask_rd_q <= {6'h00, mode_q};
          default:         mask_rd_q <= `EFB_ZERO8;
        endcase
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  assign reg_rdata = sel_mem_q ? mem_rdata : mask_rd_q;

  // Active fail-safe state follows the requests
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= EFB_FS_NONE;
    end else if (failsafe_one_req) begin
      mode_q <= EFB_FS_ONE;
    end else if (failsafe_zero_req) begin
      mode_q <= EFB_FS_ZERO;
    end else begin
      mode_q <= EFB_FS_NONE;
    end
  end

  // Channel drive from the active mask; all off outside fail-safe
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_q <= `EFB_CHAN_OFF;
    end else begin
      case (mode_q)
        EFB_FS_ZERO: chan_q <= {fs0_hi_q, fs0_lo_q};
        EFB_FS_ONE:  chan_q <= {fs1_hi_q, fs1_lo_q};
        default:     chan_q <= `EFB_CHAN_OFF;
      endcase
    end
  end

  assign chan_on                = chan_q;
  assign failsafe_active        = (mode_q != EFB_FS_NONE);
  assign stored_duty_value_ch7  = duty_flat[7:0];
  assign stored_duty_value_ch8  = duty_flat[15:8];
  assign stored_duty_value_ch9  = duty_flat[23:16];
  assign stored_duty_value_ch10 = duty_flat[31:24];
  assign stored_duty_value_ch11 = duty_flat[39:32];

  // Assertions
  // Read data is checked one cycle after the strobe, the only cycle in
  // which it stands; outside that cycle the mux shows zero. Reset checks
  // use the first edge after release, where the values set under reset
  // are still untouched by any write. Fail-safe drive is checked two
  // cycles after the request, one for the mode register and one for the
  // channel register; the extra stage keeps the outputs glitch free at
  // the cost of a cycle of latency.
  property p_duty_reset;
    @(posedge clk) $fell(rst) |-> stored_duty_value_ch8 == 8'hFF
      && stored_duty_value_ch11 == 8'hFF;
  endproperty
  a_duty_reset: assert property (p_duty_reset)
    else $error("duty reset not FFh");

  property p_duty_write;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == `EFB_OFF_DUTY7 |=> stored_duty_value_ch7
        == $past(reg_wdata);
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("ch7 duty write lost");

  property p_fs0_lo_rst;
    @(posedge clk) $fell(rst) |-> fs0_lo_q == `EFB_RST_FS0_LO;
  endproperty
  a_fs0_lo_rst: assert property (p_fs0_lo_rst)
    else $error("state 0 low mask reset wrong");

  sequence s_rd_hi0;
    reg_rd && reg_addr == `EFB_OFF_FS0_HI;
  endsequence
  property p_fs0_hi_rd;
    @(posedge clk) disable iff (rst) s_rd_hi0 |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_fs0_hi_rd: assert property (p_fs0_hi_rd)
    else $error("reserved bits of C1h not zero");

  property p_fs1_lo_rst;
    @(posedge clk) $fell(rst) |-> fs1_lo_q == `EFB_RST_FS1_LO;
  endproperty
  a_fs1_lo_rst: assert property (p_fs1_lo_rst)
    else $error("state 1 low mask reset wrong");

  property p_fs1_hi_rd;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == `EFB_OFF_FS1_HI |=>
        reg_rdata == {`EFB_HI_PAD, $past(fs1_hi_q)};
  endproperty
  a_fs1_hi_rd: assert property (p_fs1_hi_rd)
    else $error("C3h read wrong");

  property p_fs1_drive;
    @(posedge clk) disable iff (rst)
      failsafe_one_req ##1 1'b1 |=> chan_on == $past({fs1_hi_q, fs1_lo_q});
  endproperty
  a_fs1_drive: assert property (p_fs1_drive)
    else $error("state 1 channel drive wrong");

  property p_idle_off;
    @(posedge clk) disable iff (rst)
      !failsafe_one_req && !failsafe_zero_req |=> ##1 chan_on == 12'h000;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("channels on outside fail-safe");

  // Last duty entry takes a write in the next cycle
  property p_duty11_write;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == `EFB_OFF_DUTY11 |=>
        stored_duty_value_ch11 == $past(reg_wdata);
  endproperty
  a_duty11_write: assert property (p_duty11_write)
    else $error("ch11 duty write lost");

  // Duty read returns the stored value of the cycle of the strobe
  property p_duty8_rd;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == `EFB_OFF_DUTY8 |=>
        reg_rdata == $past(stored_duty_value_ch8);
  endproperty
  a_duty8_rd: assert property (p_duty8_rd)
    else $error("ch8 duty read wrong");

  // State 0 upper nibble starts disabled
  property p_fs0_hi_rst;
    @(posedge clk) $fell(rst) |-> fs0_hi_q == `EFB_RST_FS0_HI;
  endproperty
  a_fs0_hi_rst: assert property (p_fs0_hi_rst)
    else $error("state 0 high mask reset wrong");

  // State 1 upper nibble starts enabled
  property p_fs1_hi_rst;
    @(posedge clk) $fell(rst) |-> fs1_hi_q == `EFB_RST_FS1_HI;
  endproperty
  a_fs1_hi_rst: assert property (p_fs1_hi_rst)
    else $error("state 1 high mask reset wrong");

  // State 0 low mask reads back whole
  property p_fs0_lo_rd;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == `EFB_OFF_FS0_LO |=> reg_rdata == $past(fs0_lo_q);
  endproperty
  a_fs0_lo_rd: assert property (p_fs0_lo_rd)
    else $error("C0h read wrong");

  // State 1 low mask reads back whole
  property p_fs1_lo_rd;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == `EFB_OFF_FS1_LO |=> reg_rdata == $past(fs1_lo_q);
  endproperty
  a_fs1_lo_rd: assert property (p_fs1_lo_rd)
    else $error("C2h read wrong");

  // Only the low nibble of a state 0 high write is kept
  property p_fs0_hi_wr;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == `EFB_OFF_FS0_HI |=>
        fs0_hi_q == $past(reg_wdata[3:0]);
  endproperty
  a_fs0_hi_wr: assert property (p_fs0_hi_wr)
    else $error("C1h write lost");

  // Only the low nibble of a state 1 high write is kept
  property p_fs1_hi_wr;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == `EFB_OFF_FS1_HI |=>
        fs1_hi_q == $past(reg_wdata[3:0]);
  endproperty
  a_fs1_hi_wr: assert property (p_fs1_hi_wr)
    else $error("C3h write lost");

  // State 0 low mask takes a full byte
  property p_fs0_lo_wr;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == `EFB_OFF_FS0_LO |=> fs0_lo_q == $past(reg_wdata);
  endproperty
  a_fs0_lo_wr: assert property (p_fs0_lo_wr)
    else $error("C0h write lost");

  // State 0 alone drives the state 0 mask two cycles on
  sequence s_fs0_only;
    failsafe_zero_req && !failsafe_one_req;
  endsequence
  property p_fs0_drive;
    @(posedge clk) disable iff (rst)
      s_fs0_only ##1 1'b1 |=> chan_on == $past({fs0_hi_q, fs0_lo_q});
  endproperty
  a_fs0_drive: assert property (p_fs0_drive)
    else $error("state 0 channel drive wrong");

  // Any request shows as active one cycle later
  property p_active;
    @(posedge clk) disable iff (rst)
      failsafe_zero_req || failsafe_one_req |=> failsafe_active;
  endproperty
  a_active: assert property (p_active)
    else $error("fail-safe not active after request");
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the fail-safe config bank: registers and outputs.
// Assumes efb_pkg is compiled first and efb_consts.svh is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "efb_consts.svh"
module tb_top
  import efb_pkg::*;
;
  // Clock, reset and register port
  logic      clk;
  logic      rst;
  logic [7:0] reg_addr;
  efb_byte_t reg_wdata;
  logic      reg_wr;
  logic      reg_rd;
  efb_byte_t reg_rdata;
  // Fail-safe requests and outputs
  logic      failsafe_zero_req;
  logic      failsafe_one_req;
  efb_mask_t chan_on;
  logic      failsafe_active;
  efb_byte_t duty [5];  // Index 0 is channel 7
  // Bookkeeping
  int        fail_count;
  int        compares;
  int        cycles;

  efb_bank efb_bank_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .failsafe_zero_req(failsafe_zero_req),
    .failsafe_one_req(failsafe_one_req), .chan_on(chan_on),
    .failsafe_active(failsafe_active), .stored_duty_value_ch7(duty[0]),
    .stored_duty_value_ch8(duty[1]), .stored_duty_value_ch9(duty[2]),
    .stored_duty_value_ch10(duty[3]), .stored_duty_value_ch11(duty[4]));

  // 20 MHz clock
  always #25 clk = ~clk;

  // Cuts a hang short; the full run needs well under 150 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      $display("Timeout after %0d cycles", cycles);
      final_report();
    end
  end

  // Counts every compare and reports a mismatch at once
  task automatic chk(input string what, input logic [11:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input efb_byte_t d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe; data is only valid in the following cycle
  task automatic rd_chk(input logic [7:0] a, input efb_byte_t exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", {4'h0, reg_rdata}, {4'h0, exp});
  endtask

  // Enter a fail-safe state, check one and two cycle latencies, then leave
  task automatic fs_chk(input logic z, o, input efb_mask_t exp);
    @(posedge clk);
    failsafe_zero_req <= z;
    failsafe_one_req  <= o;
    @(negedge clk);
    chk("failsafe_active early", {11'h000, failsafe_active}, 12'h000);
    @(negedge clk);
    chk("failsafe_active", {11'h000, failsafe_active}, 12'h001);
    chk("chan_on early", chan_on, 12'h000);
    @(negedge clk);
    chk("chan_on", chan_on, exp);
    @(posedge clk);
    failsafe_zero_req <= 1'b0;
    failsafe_one_req  <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk("failsafe_active off", {11'h000, failsafe_active}, 12'h000);
    @(negedge clk);
    chk("chan_on off", chan_on, 12'h000);
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence: reset values, fail-safe, writes, masks, unmapped places
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failsafe_zero_req = 1'b0;
    failsafe_one_req = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    for (int i = 0; i < 5; i++) chk("duty reset", {4'h0, duty[i]}, 12'h0FF);
    for (int i = 0; i < 5; i++) rd_chk(8'hA7 + i[7:0], 8'hFF);
    rd_chk(8'hC0, 8'h00);
    rd_chk(8'hC1, 8'h00);
    rd_chk(8'hC2, 8'hFF);
    rd_chk(8'hC3, 8'h0F);
    fs_chk(1'b1, 1'b0, 12'h000);
    fs_chk(1'b0, 1'b1, 12'hFFF);
    // Distinct pattern per register; reserved upper bits written nonzero
    for (int i = 0; i < 5; i++) wr(8'hA7 + i[7:0], 8'h11 * (i[7:0] + 8'h01));
    wr(8'hC0, 8'h5A);
    wr(8'hC1, 8'hFF);
    wr(8'hC2, 8'h3C);
    wr(8'hC3, 8'hA5);
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'hA7 + i[7:0], 8'h11 * (i[7:0] + 8'h01));
      chk("duty out", {4'h0, duty[i]}, {4'h0, 8'h11 * (i[7:0] + 8'h01)});
    end
    rd_chk(8'hC0, 8'h5A);
    rd_chk(8'hC1, 8'h0F);
    rd_chk(8'hC2, 8'h3C);
    rd_chk(8'hC3, 8'h05);
    fs_chk(1'b1, 1'b0, 12'hF5A);
    fs_chk(1'b0, 1'b1, 12'h53C);
    fs_chk(1'b1, 1'b1, 12'h53C);
    // Status shows state 1 while it is requested, none afterwards
    @(posedge clk);
    failsafe_one_req <= 1'b1;
    rd_chk(8'hCF, 8'h02);
    @(posedge clk);
    failsafe_one_req <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(8'hCF, 8'h00);
    // Neighbours just outside the bank stay empty
    wr(8'hA6, 8'h77);
    rd_chk(8'hA6, 8'h00);
    rd_chk(8'hAC, 8'h00);
    rd_chk(8'hC4, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
